// [src/vpw_link_mode_control.sv]
// VPW protocol unit mode, filter, sleep, loopback and prescaler control with APB slave
//
// Summary of operation
// - 256-bit filter indexed by first byte
// - Own frame received when filter bit set
// - Filtered own ID suppresses full/overrun/EOD
// - Sleep ignores data until end-of-frame
// - Break sets break flag during sleep
// - EOF or break clears sleep
// - Sleep write ignored after EOF, bus passive
// - Sleep aborts queued response, keeps message
// - Sleep while transmitting keeps transmit flags
// - Normalization symbol form selects long/short
// - Loopback routes tx to rx, pin passive
// - Prescale divides clock by divisor plus one
// - Enable/disable bits select three modes
// - Enabled mode runs everything
// - Suspended keeps only decoder running
// - Suspended holds status, error, sleep reset
// - Disabled stops decoder, waits fresh idle
//
// Our own choices: the register offsets and the APB slave port.
`timescale 1ns/1ps
`include "vpw_link_regs.svh"
module vpw_link_mode_control
    import vpw_link_pkg::*;
#(
    parameter int FILTER_BITS = 256
)(
    // Clock and reset
    input  wire logic              mclk,
    input  wire logic              sys_rst,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Bus pins toward the transceiver
    input  wire logic              busRxPin,
    output logic                   busTxPin,
    // Codec side: raw transmit level and decoder events
    input  wire logic              codecTxActive,
    input  wire logic [7:0]        decodedByte,
    input  wire logic [`EV_W-1:0]  decodedEvent,
    input  wire logic              respQueued,
    // Controls toward codec
    output logic                   busRxLevel,
    output logic                   timeTick,
    output logic                   decoderRun,
    output logic                   codecRun,
    output logic                   respAbort,
    output logic                   nb0LongSymbol,
    output logic                   nb1LongSymbol
);
    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [1:0]             ctrl_ff;        // Enable and disable bits
    option_reg_t               opt_ff;         // Option bits
    logic [`PRESC_W-1:0]    presc_ff;       // Prescale divisor
    logic [`PRESC_W-1:0]    prescCnt_ff;    // Prescale counter
    logic                   sleep_ff;       // Sleep request
    status_t                status_ff;      // Status flags
    errors_t                errors_ff;      // Error flags
    logic [7:0]             rxByte_ff;      // Receive data register
    logic [FILTER_BITS-1:0] filter_ff;      // Identifier filter array
    logic                   expectId_ff;    // Next byte is frame identifier
    logic                   frameDrop_ff;   // Frame filtered out
    logic                   lastEof_ff;     // Last valid symbol was EOF
    logic                   waitIdle_ff;    // Waiting for fresh idle
    logic                   rxSync1_ff;     // Pin synchroniser first stage
    logic                   rxSync2_ff;     // Pin synchroniser second stage
    unit_mode_t             mode;           // Decoded mode
    logic                   wrEn;           // Write access edge
    logic                   rdEn;           // Read access edge
    logic                   quiet;          // Receive side flags suppressed
    logic                   idOk;           // Filter verdict for this byte
    logic [`EV_W-1:0]       ev;             // Events gated by mode
    logic                   rxInternal;     // Bus level seen by decoder
    logic [5:0]             filtWord;       // Filter word index

    assign wrEn = psel & penable & pwrite;
    assign rdEn = psel & penable & ~pwrite;
    assign filtWord = 6'(paddr[11:2] - 10'(`FILT_OFS >> 2));

    // ------------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------------
    // Forbidden both-set case treated as disabled, the safer outcome
    always_comb
    begin
        if (ctrl_ff[`CTRL_DIS])
            mode = MODE_DISABLED;
        else if (ctrl_ff[`CTRL_EN])
            mode = MODE_ENABLED;
        else
            mode = MODE_SUSPENDED;
    end

    // Events pass only while enabled and synchronised to the bus
    assign ev = (mode == MODE_ENABLED && !waitIdle_ff) ? decodedEvent : '0;

    // ------------------------------------------------------------------
    // Input path: synchroniser, loopback, polarity
    // ------------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            rxSync1_ff <= 1'b0;
            rxSync2_ff <= 1'b0;
        end
        else
        begin
            rxSync1_ff <= busRxPin;
            rxSync2_ff <= rxSync1_ff;
        end
    end

    // Loopback bypasses the pin and the polarity inversion
    always_comb
    begin
        if (opt_ff.loopbackSelect)
            rxInternal = codecTxActive;
        else
            rxInternal = rxSync2_ff ^ opt_ff.rxPolaritySelect;
    end

    // Outputs toward the codec and pin, all registered
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            busTxPin      <= 1'b0;
            busRxLevel    <= 1'b0;
            decoderRun    <= 1'b0;
            codecRun      <= 1'b0;
            respAbort     <= 1'b0;
            nb0LongSymbol <= 1'b1;
            nb1LongSymbol <= 1'b0;
        end
        else
        begin
            busTxPin      <= codecTxActive & ~opt_ff.loopbackSelect;
            busRxLevel    <= rxInternal;
            decoderRun    <= (mode != MODE_DISABLED);
            codecRun      <= (mode == MODE_ENABLED) && !waitIdle_ff;
            // Only the in-frame response is dropped; message stays queued
            respAbort     <= wrEn && paddr == `SLEEP_OFS && pwdata[0] && mode == MODE_ENABLED
                             && !(lastEof_ff && !rxInternal) && respQueued;
            nb0LongSymbol <= ~opt_ff.normSymbolSelect;
            nb1LongSymbol <= opt_ff.normSymbolSelect;
        end
    end

    // ------------------------------------------------------------------
    // Prescaler
    // ------------------------------------------------------------------
    // Reloads each divisor+1 cycles; stops with the decoder
    always_ff @(posedge mclk)
    begin
        if (sys_rst || mode == MODE_DISABLED)
        begin
            prescCnt_ff <= '0;
            timeTick    <= 1'b0;
        end
        else if (prescCnt_ff >= presc_ff)
        begin
            prescCnt_ff <= '0;
            timeTick    <= 1'b1;
        end
        else
        begin
            prescCnt_ff <= prescCnt_ff + 1'b1;
            timeTick    <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Control and option registers
    // ------------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            ctrl_ff  <= '0;
            opt_ff   <= '0;
            presc_ff <= `RST_PRESC;
        end
        else if (wrEn)
        begin
            if (paddr == `CTRL_OFS)
                ctrl_ff <= pwdata[1:0];
            else if (paddr == `OPT_OFS)
                opt_ff <= pwdata[2:0];
            else if (paddr == `PRESC_OFS)
                presc_ff <= pwdata[`PRESC_W-1:0];
        end
    end

    // Filter array, 32 bytes at 8 words of 32 bits
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
            filter_ff <= '0;
        else if (wrEn && paddr >= `FILT_OFS && paddr <= `FILT_END)
            filter_ff[filtWord*32 +: 32] <= pwdata;
    end

    // ------------------------------------------------------------------
    // Frame tracking: filter verdict, last EOF, idle wait
    // ------------------------------------------------------------------
    assign idOk  = filter_ff[decodedByte];
    assign quiet = sleep_ff | frameDrop_ff | (expectId_ff & ~idOk);

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            expectId_ff  <= 1'b0;
            frameDrop_ff <= 1'b0;
            lastEof_ff   <= 1'b1;
            waitIdle_ff  <= 1'b1;
        end
        else
        begin
            // Decoder stopped: resync needs a fresh idle
            if (mode == MODE_DISABLED)
                waitIdle_ff <= 1'b1;
            else if (decodedEvent[`EV_IDLE])
                waitIdle_ff <= 1'b0;
            if (ev[`EV_SOF])
            begin
                expectId_ff  <= 1'b1;
                frameDrop_ff <= 1'b0;
                lastEof_ff   <= 1'b0;
            end
            else if (ev[`EV_BYTE] && expectId_ff)
            begin
                expectId_ff  <= 1'b0;
                frameDrop_ff <= ~idOk;
            end
            if (ev[`EV_EOF])
            begin
                frameDrop_ff <= 1'b0;
                lastEof_ff   <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Sleep request
    // ------------------------------------------------------------------
    // Set wins over the end-of-frame clear so a late write is kept
    always_ff @(posedge mclk)
    begin
        if (sys_rst || mode != MODE_ENABLED)
            sleep_ff <= 1'b0;
        else if (wrEn && paddr == `SLEEP_OFS && pwdata[0]
                 && !(lastEof_ff && !rxInternal))
            sleep_ff <= 1'b1;
        else if (ev[`EV_EOF] || ev[`EV_BRK])
            sleep_ff <= 1'b0;
    end

    // ------------------------------------------------------------------
    // Receive data and status flags
    // ------------------------------------------------------------------
    // Flags clear on write-one; a same-cycle event wins
    always_ff @(posedge mclk)
    begin
        if (sys_rst || mode != MODE_ENABLED)
        begin
            status_ff <= '0;
            rxByte_ff <= `RST_ZERO8;
        end
        else
        begin
            if (wrEn && paddr == `STATUS_OFS)
                status_ff <= status_ff & ~status_t'(pwdata[7:0]);
            if (ev[`EV_BYTE] && !quiet)
            begin
                rxByte_ff          <= decodedByte;
                status_ff.rxFull   <= 1'b1;
                if (status_ff.rxFull)
                    status_ff.rxOverrun <= 1'b1;
            end
            if (ev[`EV_EOD] && !quiet)
                status_ff.endOfData <= 1'b1;
            if (ev[`EV_RDT] && !quiet)
                status_ff.rxTransfer <= 1'b1;
            if (ev[`EV_EOF])
                status_ff.endOfFrame <= 1'b1;
            if (ev[`EV_TX_READY_FLAG])
                status_ff.txReady <= 1'b1;
            if (ev[`EV_TLA])
                status_ff.txLostArb <= 1'b1;
            if (ev[`EV_IDLE])
                status_ff.idle <= 1'b1;
        end
    end

    // Errors: break always, receive errors unless sleeping while not transmitting
    always_ff @(posedge mclk)
    begin
        if (sys_rst || mode != MODE_ENABLED)
            errors_ff <= '0;
        else
        begin
            if (wrEn && paddr == `ERROR_OFS)
                errors_ff <= errors_ff & ~errors_t'(pwdata[7:0]);
            if (ev[`EV_BRK])
                errors_ff.rxBreak <= 1'b1;
            if (ev[`EV_CRC] && (!sleep_ff || codecTxActive))
                errors_ff.crcError <= 1'b1;
            if (ev[`EV_IFD] && (!sleep_ff || codecTxActive))
                errors_ff.invalidFrame <= 1'b1;
            if (ev[`EV_IBD] && (!sleep_ff || codecTxActive))
                errors_ff.invalidBit <= 1'b1;
            if (ev[`EV_TTO])
                errors_ff.txTimeout <= 1'b1;
            if (ev[`EV_TX_UNDERFLOW_FLAG])
                errors_ff.txUnderflow <= 1'b1;
            if (ev[`EV_TRA])
                errors_ff.txReqAborted <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // APB read path, zero-wait answer
    // ------------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            prdata  <= '0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= psel & ~penable;
            pslverr <= 1'b0;
            prdata  <= '0;
            if (psel && !penable && !pwrite)
            begin
                if (paddr == `CTRL_OFS)
                    prdata <= {30'h0, ctrl_ff};
                else if (paddr == `OPT_OFS)
                    prdata <= {29'h0, opt_ff};
                else if (paddr == `PRESC_OFS)
                    prdata <= {26'h0, presc_ff};
                else if (paddr == `SLEEP_OFS)
                    prdata <= {31'h0, sleep_ff};
                else if (paddr == `STATUS_OFS)
                    prdata <= {24'h0, status_ff};
                else if (paddr == `ERROR_OFS)
                    prdata <= {24'h0, errors_ff};
                else if (paddr == `RX_BYTE_REG_OFS)
                    prdata <= {24'h0, rxByte_ff};
                else if (paddr >= `FILT_OFS && paddr <= `FILT_END)
                    prdata <= filter_ff[filtWord*32 +: 32];
                else
                    pslverr <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    tick_period_a: assert property (@(posedge mclk) disable iff (sys_rst)
        $rose(timeTick) && $stable(presc_ff) && presc_ff != '0 |=> !timeTick)
        else $error("timing pulse longer than one cycle");
    susp_clear_a: assert property (@(posedge mclk) disable iff (sys_rst)
        mode == MODE_SUSPENDED |=> sleep_ff == 1'b0 && status_ff == '0 && errors_ff == '0)
        else $error("suspended state not held at reset");
    loop_pin_a: assert property (@(posedge mclk) disable iff (sys_rst)
        opt_ff.loopbackSelect && $past(opt_ff.loopbackSelect) |-> !busTxPin)
        else $error("tx pin driven in loopback");
    eof_wake_a: assert property (@(posedge mclk) disable iff (sys_rst)
        ev[`EV_EOF] && !wrEn |=> !sleep_ff)
        else $error("sleep not cleared by end of frame");
    brk_sleep_a: assert property (@(posedge mclk) disable iff (sys_rst)
        ev[`EV_BRK] && mode == MODE_ENABLED ##1 mode == MODE_ENABLED |-> errors_ff.rxBreak)
        else $error("break lost");
    sleep_quiet_a: assert property (@(posedge mclk) disable iff (sys_rst)
        sleep_ff && ev[`EV_BYTE] && !status_ff.rxFull |=> !status_ff.rxFull)
        else $error("byte received while asleep");
    nb_form_a: assert property (@(posedge mclk) disable iff (sys_rst)
        nb1LongSymbol == $past(opt_ff.normSymbolSelect) && nb0LongSymbol != nb1LongSymbol)
        else $error("normalization forms equal");
    dis_stop_a: assert property (@(posedge mclk) disable iff (sys_rst)
        mode == MODE_DISABLED |=> !decoderRun && !codecRun)
        else $error("decoder runs while disabled");
endmodule : vpw_link_mode_control

// [src/vpw_link_pkg.sv]
// Types shared by the VPW mode control block
package vpw_link_pkg;
    // Operating mode selected by enable and disable bits
    typedef enum logic [1:0] {MODE_SUSPENDED, MODE_ENABLED, MODE_DISABLED} unit_mode_t;
    // Receive and transmit status flags
    typedef struct packed {
        logic rxFull;
        logic rxOverrun;
        logic endOfData;
        logic endOfFrame;
        logic rxTransfer;
        logic txReady;
        logic txLostArb;
        logic idle;
    } status_t;
    // Error flags
    typedef struct packed {
        logic rxBreak;
        logic crcError;
        logic invalidFrame;
        logic invalidBit;
        logic txTimeout;
        logic txUnderflow;
        logic txReqAborted;
        logic spare;
    } errors_t;
    // Option bits
    typedef struct packed {
        logic loopbackSelect;
        logic rxPolaritySelect;
        logic normSymbolSelect;
    } option_reg_t;
endpackage : vpw_link_pkg

// [src/vpw_link_regs.svh]
// Register offsets, field positions, reset values and event bit positions of the VPW mode control
`ifndef VPW_LINK_REGS_SVH
`define VPW_LINK_REGS_SVH
// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define CTRL_OFS     12'h000
`define OPT_OFS      12'h004
`define PRESC_OFS    12'h008
`define SLEEP_OFS    12'h00C
`define STATUS_OFS   12'h010
`define ERROR_OFS    12'h014
`define RX_BYTE_REG_OFS   12'h018
`define EVENT_OFS    12'h01C
`define FILT_OFS     12'h020
`define FILT_END     12'h03C
// ----------------------------------------------------------------------
// Field positions, widths, reset values and mode codes
// ----------------------------------------------------------------------
`define CTRL_EN      0
`define CTRL_DIS     1
`define OPT_NBS      0
`define OPT_POL      1
`define OPT_LOOP     2
`define PRESC_W      6
`define RST_PRESC    6'h13
`define RST_ZERO8    8'h00
`define MODE_DIS     2'h2
`define MODE_SUSP    2'h0
`define MODE_EN      2'h1
// Event input bit positions
`define EV_SOF       0
`define EV_BYTE      1
`define EV_EOD       2
`define EV_EOF       3
`define EV_BRK       4
`define EV_CRC       5
`define EV_IFD       6
`define EV_IBD       7
`define EV_TX_READY_FLAG      8
`define EV_TLA       9
`define EV_TTO       10
`define EV_TX_UNDERFLOW_FLAG      11
`define EV_TRA       12
`define EV_RDT       13
`define EV_IDLE      14
`define EV_W         15
`endif

// [test/tb.sv]
// Self-checking bench for the VPW mode control block
`timescale 1ns/1ps
`include "vpw_link_regs.svh"
module tb;
    import vpw_link_pkg::*;
    // -----------------------------------------------------------
    // Signals
    // -----------------------------------------------------------
    logic mclk, sys_rst, psel, penable, pwrite, pready, pslverr, slv;
    logic busRxPin, busTxPin, codecTxActive, respQueued, invertRx, otherDrive;
    logic busRxLevel, timeTick, decoderRun, codecRun, respAbort;
    logic nb0LongSymbol, nb1LongSymbol;
    logic [11:0]       paddr;
    logic [31:0]       pwdata, prdata, q;
    logic [7:0]        decodedByte;
    logic [`EV_W-1:0]  decodedEvent;
    int                errors, cmpCount, cyc, abortSeen, n;

    vpw_link_mode_control u_vpw_link_mode_control (.mclk, .sys_rst, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .busRxPin, .busTxPin,
        .codecTxActive, .decodedByte, .decodedEvent, .respQueued, .busRxLevel,
        .timeTick, .decoderRun, .codecRun, .respAbort, .nb0LongSymbol, .nb1LongSymbol);
    vpw_xcvr_model u_vpw_xcvr_model (.txLevel(busTxPin), .invertRx(invertRx),
        .otherDrive(otherDrive), .rxPin(busRxPin));

    // Clock, watchdog and abort pulse counter
    always #25 mclk = ~mclk;
    always @(posedge mclk)
    begin
        cyc <= cyc + 1;
        if (respAbort === 1'b1)
            abortSeen <= abortSeen + 1;
        if (cyc == 6000)
        begin
            errors++;
            conclude();
        end
    end

    // -----------------------------------------------------------
    // Tasks
    // -----------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        cmpCount++;
        if (got !== exp)
        begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    // One APB transfer; two idle edges follow so calls never collide
    // Waits for pready as long as needed; only the watchdog ends a hang
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1)
        begin
            @(posedge mclk);
        end
        q = prdata;
        slv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        repeat (2) @(posedge mclk);
    endtask : apb
    task automatic rdc(input logic [11:0] a, input logic [31:0] e, input string nm);
        apb(1'b0, a, 32'h0);
        chk(nm, q, e);
    endtask : rdc
    // Single-cycle decoder event
    task automatic ev(input int b, input logic [7:0] d);
        decodedByte <= d;
        decodedEvent[b] <= 1'b1;
        @(posedge mclk);
        decodedEvent <= '0;
        repeat (2) @(posedge mclk);
    endtask : ev
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmpCount, errors);
        if (errors == 0 && cmpCount > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : conclude

    // -----------------------------------------------------------
    // Sequence
    // -----------------------------------------------------------
    initial
    begin
        {mclk, psel, penable, pwrite, codecTxActive, respQueued} = '0;
        {invertRx, otherDrive, paddr, pwdata, decodedByte, decodedEvent} = '0;
        {errors, cmpCount, cyc, abortSeen} = '0;
        sys_rst = 1'b1;
        repeat (8) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        rdc(`PRESC_OFS, 32'h13, "prescale");
        chk("nb0", 32'(nb0LongSymbol), 32'h1);
        $display("reset test done");
        // Modes: disabled, suspended, enabled needing fresh idle
        apb(1'b1, `CTRL_OFS, 32'h2);
        chk("decRunDis", 32'({decoderRun, codecRun}), 32'h0);
        apb(1'b1, `CTRL_OFS, 32'h0);
        chk("decRunSusp", 32'({decoderRun, codecRun}), 32'h2);
        apb(1'b1, `CTRL_OFS, 32'h1);
        chk("noResync", 32'(codecRun), 32'h0);
        ev(`EV_IDLE, 8'h00);
        chk("codecRun", 32'(codecRun), 32'h1);
        $display("mode test done");
        // Prescaler period of divisor plus one
        apb(1'b1, `PRESC_OFS, 32'h3);
        for (n = 0; timeTick !== 1'b1 && n < 99; n++)
            @(posedge mclk);
        @(posedge mclk);
        for (n = 1; timeTick !== 1'b1 && n < 99; n++)
            @(posedge mclk);
        chk("tickGap", 32'(n), 32'h4);
        $display("prescale test done");
        // Symbol forms, polarity, loopback (loopback changed while suspended)
        for (int v = 0; v < 2; v++)
        begin
            apb(1'b1, `OPT_OFS, 32'(v));
            chk("nbForm", 32'({nb0LongSymbol, nb1LongSymbol}), v ? 32'h1 : 32'h2);
        end
        invertRx <= 1'b1;
        otherDrive <= 1'b1;
        apb(1'b1, `OPT_OFS, 32'h2);
        chk("polAct", 32'(busRxLevel), 32'h1);
        otherDrive <= 1'b0;
        repeat (4) @(posedge mclk);
        chk("polPas", 32'(busRxLevel), 32'h0);
        invertRx <= 1'b0;
        apb(1'b1, `CTRL_OFS, 32'h0);
        codecTxActive <= 1'b1;
        apb(1'b1, `OPT_OFS, 32'h4);
        chk("loopOn", 32'({busTxPin, busRxLevel}), 32'h1);
        codecTxActive <= 1'b0;
        otherDrive <= 1'b1;
        repeat (3) @(posedge mclk);
        chk("pinIgnored", 32'(busRxLevel), 32'h0);
        otherDrive <= 1'b0;
        apb(1'b1, `OPT_OFS, 32'h0);
        apb(1'b1, `CTRL_OFS, 32'h1);
        ev(`EV_IDLE, 8'h00);
        $display("option test done");
        // Filter: own frame accepted, own frame rejected, top index
        apb(1'b1, `FILT_OFS + 12'h004, 32'h0000_0020);
        apb(1'b1, `FILT_OFS + 12'h01C, 32'h8000_0000);
        codecTxActive <= 1'b1;
        for (int i = 0; i < 2; i++)
        begin
            ev(`EV_SOF, 8'h00);
            ev(`EV_BYTE, i ? 8'hFF : 8'h25);
            rdc(`RX_BYTE_REG_OFS, i ? 32'hFF : 32'h25, "rxByte");
            apb(1'b1, `STATUS_OFS, 32'hFF);
            ev(`EV_EOF, 8'h00);
        end
        ev(`EV_SOF, 8'h00);
        ev(`EV_BYTE, 8'h26);
        ev(`EV_CRC, 8'h00);
        ev(`EV_EOD, 8'h00);
        apb(1'b0, `STATUS_OFS, 32'h0);
        chk("fltStatus", q & 32'hE0, 32'h0);
        rdc(`ERROR_OFS, 32'h40, "fltCrc");
        rdc(`RX_BYTE_REG_OFS, 32'hFF, "fltData");
        ev(`EV_EOF, 8'h00);
        codecTxActive <= 1'b0;
        apb(1'b1, `ERROR_OFS, 32'hFF);
        $display("filter test done");
        // Sleep: refused after end of frame, abort, break and end of frame exits
        respQueued <= 1'b1;
        apb(1'b1, `SLEEP_OFS, 32'h1);
        rdc(`SLEEP_OFS, 32'h0, "slpRefused");
        ev(`EV_SOF, 8'h00);
        ev(`EV_BYTE, 8'h25);
        apb(1'b1, `STATUS_OFS, 32'hFF);
        apb(1'b1, `SLEEP_OFS, 32'h1);
        chk("abort", 32'(abortSeen), 32'h1);
        rdc(`SLEEP_OFS, 32'h1, "slpOn");
        ev(`EV_BYTE, 8'h25);
        ev(`EV_EOD, 8'h00);
        apb(1'b0, `STATUS_OFS, 32'h0);
        chk("slpStatus", q & 32'hE8, 32'h0);
        ev(`EV_BRK, 8'h00);
        rdc(`ERROR_OFS, 32'h80, "slpBrk");
        rdc(`SLEEP_OFS, 32'h0, "brkExit");
        respQueued <= 1'b0;
        codecTxActive <= 1'b1;
        apb(1'b1, `SLEEP_OFS, 32'h1);
        ev(`EV_TLA, 8'h00);
        ev(`EV_BYTE, 8'h25);
        ev(`EV_EOF, 8'h00);
        apb(1'b0, `STATUS_OFS, 32'h0);
        chk("txSleep", q & 32'h92, 32'h12);
        rdc(`SLEEP_OFS, 32'h0, "eofExit");
        codecTxActive <= 1'b0;
        $display("sleep test done");
        // Suspend clears flags; unmapped read refused
        apb(1'b1, `CTRL_OFS, 32'h0);
        rdc(`STATUS_OFS, 32'h0, "suspStatus");
        rdc(`ERROR_OFS, 32'h0, "suspError");
        rdc(12'h0F0, 32'h0, "unmapped");
        chk("slverr", 32'(slv), 32'h1);
        $display("suspend test done");
        conclude();
    end
endmodule : tb

// [test/vpw_xcvr_model.sv]
// Behavioural bus transceiver that echoes the shared wire to the receive pin
`timescale 1ns/1ps
module vpw_xcvr_model (
    // Node side
    input  wire logic txLevel,
    input  wire logic invertRx,
    // Other nodes on the bus
    input  wire logic otherDrive,
    // Receive pin toward the unit
    output logic      rxPin
);
    // -----------------------------------------------------------
    // Wire and echo
    // -----------------------------------------------------------
    logic busActive; // Active dominates passive
    assign busActive = txLevel | otherDrive;
    // Some chips present the wire inverted
    assign rxPin = invertRx ? ~busActive : busActive;
endmodule : vpw_xcvr_model
